/* File: inc/rx_front_pkg.sv */
// Purpose: Shared constants and types for the receive front-end control
// Assumes: 32-bit APB, one 20 MHz core clock
// Notes: Serial events reach the core as one-cycle strobes

package rx_front_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_LOS_SET = 0;
    localparam int IRQ_LOS_CLR = 1;
    localparam int IRQ_LOCK_LOST = 2;
    localparam int IRQ_LOCK_GAINED = 3;

    // ------------------------------------------------------------
    // Loss-of-signal detector, in bit periods (clear threshold in transitions)
    // ------------------------------------------------------------
    localparam logic [7:0] LOS_QUIET_BITS = 8'h80;
    localparam logic [7:0] LOS_CLEAR_TRANS = 8'h10;
    localparam int LOS_WIN_BITS = 128;

    // ------------------------------------------------------------
    // Frequency monitor: 2^11 is about 500 ppm
    // ------------------------------------------------------------
    localparam int PPM_LIMIT = 500;
    localparam int PPM_TOL_SHIFT = 11;
    localparam int FREQ_WIN_LOG2 = 12;
    // log2 of recovered / reference clock ratio
    localparam logic [2:0] RATIO_X2 = 3'h1;
    localparam logic [2:0] RATIO_X8 = 3'h3;
    localparam logic [2:0] RATIO_X32 = 3'h5;

    typedef struct packed {
        logic serial_remote_loopback;
        logic analog_local_loopback;
        logic digital_local_loopback;
        logic internal_los_disable;
        logic recovery_bypass;
        logic line_rate_select;
        logic cdr_ref_source_select;
        logic ref_freq_select;
    } ctrl_t;

    typedef enum logic [1:0] {
        ST_REF_ACQ,
        ST_REF_HOLD,
        ST_DATA,
        ST_BYPASS
    } lock_state_t;

endpackage

/* File: logic/freq_window_monitor.sv */
// Purpose: Compare recovered clock ticks against reference ticks
// Assumes: Both tick inputs are one-cycle strobes on core_clk
// Notes: Verdict refreshes once per reference window

`timescale 1ns/1ps
`default_nettype none

module freq_window_monitor #(
    parameter int WIN_LOG2 = 12,
    parameter int TOL_SHIFT = 11
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic ref_tick,
    input wire logic rec_tick,
    input wire logic [2:0] ratio_shift,
    output logic freq_ok
);
    localparam int CW = WIN_LOG2 + 7;

    logic [WIN_LOG2-1:0] win_reg;
    logic [CW-1:0] rec_reg;
    logic [CW-1:0] rec_total;
    logic [CW-1:0] expected;
    logic [CW-1:0] tol;
    logic window_end;

    assign expected = (CW'(1) << WIN_LOG2) << ratio_shift;
    assign tol = expected >> TOL_SHIFT;
    assign rec_total = rec_reg + CW'(rec_tick);
    assign window_end = enable && ref_tick && (win_reg == '1);

    // ------------------------------------------------------------
    // Window counters
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            win_reg <= '0;
            rec_reg <= '0;
            freq_ok <= 1'b0;
        end else if (!enable) begin
            win_reg <= '0;
            rec_reg <= '0;
            freq_ok <= 1'b0;
        end else if (window_end) begin
            win_reg <= '0;
            rec_reg <= '0;
            freq_ok <= (rec_total >= expected - tol) && (rec_total <= expected + tol);
        end else begin
            if (ref_tick) begin
                win_reg <= win_reg + 1'b1;
            end
            // Saturate so a runaway clock never wraps into range
            if (rec_tick && rec_reg != '1) begin
                rec_reg <= rec_total;
            end
        end
    end

endmodule

`default_nettype wire

/* File: logic/rx_front_ctrl.sv */
// Purpose: Receive front-end lock, loss-of-signal and mute control
// Assumes: Pins synchronous to core_clk; bit events arrive as strobes
// Notes: Registers over APB, zero wait state, read-clear interrupts

`timescale 1ns/1ps
`default_nettype none

module rx_front_ctrl (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_pll_locked,
    input wire logic ref_tick,
    input wire logic rec_tick,
    input wire logic serial_rx_input,
    input wire logic cdr_bit_strobe,
    input wire logic external_recovered_clock,
    input wire logic external_loss_n,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_byte_strobe,
    input wire logic loop_bit_in,
    output logic [7:0] rx_parallel_data,
    output logic rx_byte_valid,
    output logic tx_loop_bit,
    output logic remote_loop_mute,
    output logic rx_clk_from_ref,
    output logic cdr_enable,
    output logic cdr_use_aux_ref,
    output logic cdr_ref_is_19m,
    output logic cdr_out_622m,
    output logic irq
);
    import rx_front_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ctrl_t ctrl_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_events;
    lock_state_t state_reg;
    lock_state_t state_next;
    logic ext_clk_prev_reg;
    logic prev_bit_reg;
    logic [7:0] quiet_cnt_reg;
    logic [7:0] win_cnt_reg;
    logic [7:0] win_cnt_next;
    logic [LOS_WIN_BITS-1:0] hist_reg;
    logic internal_loss_detected_reg;
    logic los_prev_reg;
    logic los_combined;
    logic freq_ok;
    logic [2:0] ratio_shift;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_stat = (paddr == OFS_IRQ_STAT);
    wire hit_mask = (paddr == OFS_IRQ_MASK);
    wire addr_hit = hit_ctrl || hit_status || hit_stat || hit_mask;
    wire wr_ctrl = access_done && pwrite && hit_ctrl;
    wire wr_mask = access_done && pwrite && hit_mask;
    wire rd_stat = access_done && !pwrite && hit_stat;
    wire [31:0] status_word = {26'h0, state_reg, freq_ok,
        state_reg == ST_DATA, los_combined, internal_loss_detected_reg};
    wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_reg} :
        hit_status ? status_word :
        hit_stat ? {28'h0, irq_stat_reg} :
        hit_mask ? {28'h0, irq_mask_reg} : 32'h0;

    // ------------------------------------------------------------
    // Serial bit source selection
    // ------------------------------------------------------------
    wire ext_clk_rise = external_recovered_clock && !ext_clk_prev_reg;
    wire bit_strobe = ctrl_reg.recovery_bypass ? ext_clk_rise : cdr_bit_strobe;
    wire trans = bit_strobe && (serial_rx_input != prev_bit_reg);
    wire quiet_over = !trans && (quiet_cnt_reg >= LOS_QUIET_BITS);

    // ------------------------------------------------------------
    // Loss and mute terms
    // ------------------------------------------------------------
    wire ext_loss = !external_loss_n;
    assign los_combined = internal_loss_detected_reg || ext_loss;
    wire local_loop = ctrl_reg.digital_local_loopback || ctrl_reg.analog_local_loopback;
    wire rx_mute = los_combined && !local_loop;
    // Detector output is already zero when disabled; external term stays
    wire remote_mute = ctrl_reg.serial_remote_loopback &&
        (internal_loss_detected_reg || ext_loss);

    // ------------------------------------------------------------
    // Reference ratio for the frequency monitor
    // ------------------------------------------------------------
    wire ref_is_19m = !ctrl_reg.cdr_ref_source_select && ctrl_reg.ref_freq_select;
    assign ratio_shift = ref_is_19m ?
        (ctrl_reg.line_rate_select ? RATIO_X32 : RATIO_X8) :
        (ctrl_reg.line_rate_select ? RATIO_X8 : RATIO_X2);

    freq_window_monitor #(
        .WIN_LOG2(FREQ_WIN_LOG2),
        .TOL_SHIFT(PPM_TOL_SHIFT)
    ) u_freq (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(!ctrl_reg.recovery_bypass),
        .ref_tick(ref_tick),
        .rec_tick(rec_tick),
        .ratio_shift(ratio_shift),
        .freq_ok(freq_ok)
    );

    // ------------------------------------------------------------
    // Lock state machine
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_REF_ACQ: begin
                if (ctrl_reg.recovery_bypass) begin
                    state_next = ST_BYPASS;
                end else if (ref_pll_locked) begin
                    state_next = ST_REF_HOLD;
                end
            end
            ST_REF_HOLD: begin
                if (ctrl_reg.recovery_bypass) begin
                    state_next = ST_BYPASS;
                end else if (!ref_pll_locked) begin
                    state_next = ST_REF_ACQ;
                end else if (!los_combined && freq_ok) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (ctrl_reg.recovery_bypass) begin
                    state_next = ST_BYPASS;
                end else if (!freq_ok || los_combined) begin
                    state_next = ST_REF_HOLD;
                end
            end
            ST_BYPASS: begin
                if (!ctrl_reg.recovery_bypass) begin
                    state_next = ST_REF_ACQ;
                end
            end
            default: state_next = ST_REF_ACQ;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_REF_ACQ;
            rx_clk_from_ref <= 1'b1;
            cdr_enable <= 1'b0;
            cdr_use_aux_ref <= 1'b0;
            cdr_ref_is_19m <= 1'b0;
            cdr_out_622m <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Framer always sees a clock: reference-based unless on data or in bypass
            rx_clk_from_ref <= (state_next == ST_REF_ACQ) || (state_next == ST_REF_HOLD);
            cdr_enable <= !ctrl_reg.recovery_bypass;
            cdr_use_aux_ref <= ctrl_reg.cdr_ref_source_select;
            cdr_ref_is_19m <= ref_is_19m;
            cdr_out_622m <= ctrl_reg.line_rate_select;
        end
    end

    // ------------------------------------------------------------
    // Internal loss-of-signal detector
    // ------------------------------------------------------------
    assign win_cnt_next = win_cnt_reg + 8'(trans) - 8'(bit_strobe && hist_reg[LOS_WIN_BITS-1]);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_clk_prev_reg <= 1'b0;
            prev_bit_reg <= 1'b0;
            quiet_cnt_reg <= 8'h00;
            win_cnt_reg <= 8'h00;
            hist_reg <= '0;
        end else begin
            ext_clk_prev_reg <= external_recovered_clock;
            if (bit_strobe) begin
                prev_bit_reg <= serial_rx_input;
                hist_reg <= {hist_reg[LOS_WIN_BITS-2:0], trans};
                win_cnt_reg <= win_cnt_next;
                if (trans) begin
                    quiet_cnt_reg <= 8'h00;
                end else if (quiet_cnt_reg != 8'hff) begin
                    quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            internal_loss_detected_reg <= 1'b0;
        end else if (ctrl_reg.internal_los_disable) begin
            internal_loss_detected_reg <= 1'b0;
        end else if (bit_strobe && quiet_over) begin
            internal_loss_detected_reg <= 1'b1;
        end else if (bit_strobe && win_cnt_next >= LOS_CLEAR_TRANS) begin
            internal_loss_detected_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data paths and muting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_parallel_data <= 8'h00;
            rx_byte_valid <= 1'b0;
            tx_loop_bit <= 1'b0;
            remote_loop_mute <= 1'b0;
        end else begin
            rx_byte_valid <= rx_byte_strobe;
            // Held at zero every cycle, not just on strobes
            if (rx_mute) begin
                rx_parallel_data <= 8'h00;
            end else if (rx_byte_strobe) begin
                rx_parallel_data <= rx_byte_in;
            end
            tx_loop_bit <= remote_mute ? 1'b0 : loop_bit_in;
            remote_loop_mute <= remote_mute;
        end
    end

    // ------------------------------------------------------------
    // Registers, interrupts and bus answer
    // ------------------------------------------------------------
    assign irq_events[IRQ_LOS_SET] = los_combined && !los_prev_reg;
    assign irq_events[IRQ_LOS_CLR] = !los_combined && los_prev_reg;
    assign irq_events[IRQ_LOCK_LOST] = (state_reg == ST_DATA) && (state_next == ST_REF_HOLD);
    assign irq_events[IRQ_LOCK_GAINED] = (state_reg != ST_DATA) && (state_next == ST_DATA);
    // Only bits actually returned are cleared; new events win
    assign irq_stat_next = (irq_stat_reg & ~(rd_stat ? prdata[IRQ_W-1:0] : '0)) | irq_events;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            irq_stat_reg <= '0;
            los_prev_reg <= 1'b0;
            irq <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (wr_mask) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
            los_prev_reg <= los_combined;
            irq <= |(irq_stat_next & irq_mask_reg);
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_hit;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_RX_MUTE:
    assert property (rx_mute |=> rx_parallel_data == 8'h00)
        else $error("rx data not muted on loss");

    AST_LOOP_NO_MUTE:
    assert property (local_loop && rx_byte_strobe |=> rx_parallel_data == $past(rx_byte_in))
        else $error("local loopback data muted");

    AST_REMOTE_INT:
    assert property (ctrl_reg.serial_remote_loopback && internal_loss_detected_reg
        |=> remote_loop_mute && !tx_loop_bit)
        else $error("remote loop not muted on internal loss");

    AST_REMOTE_EXT:
    assert property (ctrl_reg.serial_remote_loopback && !external_loss_n
        && ctrl_reg.internal_los_disable |=> remote_loop_mute)
        else $error("remote loop not muted on external loss");

    AST_LOS_DISABLE:
    assert property (ctrl_reg.internal_los_disable |=> !internal_loss_detected_reg)
        else $error("disabled detector declared loss");

    AST_LOS_DECLARE:
    assert property (bit_strobe && !trans && quiet_cnt_reg == 8'h80
        && !ctrl_reg.internal_los_disable |=> internal_loss_detected_reg)
        else $error("loss not declared after 129 quiet bits");

    AST_START_REF:
    assert property (state_reg == ST_REF_ACQ |=> state_reg != ST_DATA)
        else $error("data lock before reference lock");

    AST_DATA_ENTRY:
    assert property ($rose(state_reg == ST_DATA) |-> $past(external_loss_n && freq_ok
        && !internal_loss_detected_reg))
        else $error("data lock without clean conditions");

    AST_DROP_DATA:
    assert property (state_reg == ST_DATA && !freq_ok && !ctrl_reg.recovery_bypass
        |=> state_reg == ST_REF_HOLD ##1 rx_clk_from_ref)
        else $error("data lock kept with bad frequency");

    AST_BYPASS:
    assert property (ctrl_reg.recovery_bypass |=> !cdr_enable && state_reg == ST_BYPASS)
        else $error("bypass did not disable recovery");

endmodule

`default_nettype wire

/* File: sim/line_partner.sv */
// Purpose: Far side model: optical module, serial line and reference clocks
// Assumes: Every output changes just after core_clk rises
// Notes: One serial bit every second cycle; external clock runs only in bypass

`timescale 1ns/1ps
`default_nettype none

module line_partner (
    input wire logic core_clk,
    input wire logic toggle_bits,
    input wire logic bypass_mode,
    input wire logic rec_bad,
    input wire logic pll_lock,
    input wire logic loss_req,
    output logic ref_pll_locked = 1'b0,
    output logic ref_tick = 1'b0,
    output logic rec_tick = 1'b0,
    output logic serial_rx_input = 1'b0,
    output logic cdr_bit_strobe = 1'b0,
    output logic external_recovered_clock = 1'b0,
    output logic external_loss_n = 1'b1
);
    logic phase = 1'b0;

    // ------------------------------------------------------------
    // Line and clock behaviour
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        phase <= !phase;
        ref_pll_locked <= pll_lock;
        ref_tick <= phase;
        // Good rate is twice the reference; bad rate equals it
        rec_tick <= !rec_bad || phase;
        external_loss_n <= !loss_req;
        cdr_bit_strobe <= phase && !bypass_mode;
        // Stands still low outside bypass
        external_recovered_clock <= bypass_mode && phase;
        if (!phase && toggle_bits) begin
            serial_rx_input <= !serial_rx_input;
        end
    end
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the receive front-end control
// Assumes: Zero wait state APB; partner model drives the line side
// Notes: Bus answers and the rx_clk_from_ref checks of t_lock taken at the rising edge, other outputs at the falling

`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rx_front_pkg::*;

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ref_pll_locked, ref_tick, rec_tick, serial_rx_input;
    logic cdr_bit_strobe, external_recovered_clock, external_loss_n;
    logic [7:0] rx_byte_in = 8'h00;
    logic rx_byte_strobe = 1'b0;
    logic loop_bit_in = 1'b1;
    logic [7:0] rx_parallel_data;
    logic rx_byte_valid, tx_loop_bit, remote_loop_mute, rx_clk_from_ref;
    logic cdr_enable, cdr_use_aux_ref, cdr_ref_is_19m, cdr_out_622m, irq;
    logic toggle_bits = 1'b1;
    logic bypass_mode = 1'b0;
    logic rec_bad = 1'b0;
    logic pll_lock = 1'b0;
    logic loss_req = 1'b0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int cmp_count = 0;

    always #25 core_clk = !core_clk;

    rx_front_ctrl rx_front_ctrl_i (.core_clk, .nrst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .ref_pll_locked, .ref_tick, .rec_tick,
        .serial_rx_input, .cdr_bit_strobe, .external_recovered_clock, .external_loss_n,
        .rx_byte_in, .rx_byte_strobe, .loop_bit_in, .rx_parallel_data, .rx_byte_valid,
        .tx_loop_bit, .remote_loop_mute, .rx_clk_from_ref, .cdr_enable, .cdr_use_aux_ref,
        .cdr_ref_is_19m, .cdr_out_622m, .irq);

    line_partner line_partner_i (.core_clk, .toggle_bits, .bypass_mode, .rec_bad,
        .pll_lock, .loss_req, .ref_pll_locked, .ref_tick, .rec_tick, .serial_rx_input,
        .cdr_bit_strobe, .external_recovered_clock, .external_loss_n);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            done = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            n++;
            if (!done && n > 8) begin
                chk("pready", 32'h1, 32'h0);
                stop_test();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input string what);
        apb(1'b0, a, 32'h0);
        chk(what, e, rd & m);
    endtask

    task automatic byte_chk(input logic [7:0] b, input logic [7:0] e);
        @(posedge core_clk);
        rx_byte_in <= b;
        rx_byte_strobe <= 1'b1;
        @(posedge core_clk);
        rx_byte_strobe <= 1'b0;
        @(negedge core_clk);
        chk("rx_byte_valid", 32'h1, {31'h0, rx_byte_valid});
        chk("rx_parallel_data", {24'h0, e}, {24'h0, rx_parallel_data});
    endtask

    task automatic wait_state(input logic [1:0] st, input int tries);
        int n;
        n = 0;
        do begin
            look(64);
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[5:4] !== st && n < tries);
        chk("lock state", {30'h0, st}, {30'h0, rd[5:4]});
        if (rd[5:4] !== st) begin
            stop_test();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("rx_clk_from_ref", 32'h1, {31'h0, rx_clk_from_ref});
        rchk(OFS_CTRL, 32'hffffffff, {24'h0, CTRL_RESET}, "ctrl");
        rchk(OFS_IRQ_MASK, 32'hffffffff, {28'h0, IRQ_MASK_RESET}, "mask");
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, OFS_STATUS, 32'hff);
        rchk(OFS_STATUS, 32'h30, 32'h0, "state");
        $display("Test reset done");
    endtask

    task automatic t_cfg();
        logic [7:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[7:0];
            apb(1'b1, OFS_CTRL, {24'h0, c});
            look(1);
            chk("cdr_enable", {31'h0, !c[3]}, {31'h0, cdr_enable});
            chk("aux ref", {31'h0, c[1]}, {31'h0, cdr_use_aux_ref});
            chk("ref 19m", {31'h0, c[0] & !c[1]}, {31'h0, cdr_ref_is_19m});
            chk("out 622m", {31'h0, c[2]}, {31'h0, cdr_out_622m});
        end
        rchk(OFS_STATUS, 32'h30, 32'h30, "bypass state");
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("Test config done");
    endtask

    task automatic t_loss();
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        toggle_bits <= 1'b0;
        look(240);
        rchk(OFS_STATUS, 32'h1, 32'h0, "loss early");
        look(40);
        rchk(OFS_STATUS, 32'h3, 32'h3, "loss");
        byte_chk(8'h5a, 8'h00);
        chk("irq", 32'h1, {31'h0, irq});
        rchk(OFS_IRQ_STAT, 32'h1, 32'h1, "loss event");
        rchk(OFS_IRQ_STAT, 32'h1, 32'h0, "read clear");
        toggle_bits <= 1'b1;
        look(20);
        rchk(OFS_STATUS, 32'h1, 32'h1, "loss held");
        look(40);
        rchk(OFS_STATUS, 32'h3, 32'h0, "loss clear");
        byte_chk(8'h5a, 8'h5a);
        chk("irq masked", 32'h0, {31'h0, irq});
        rchk(OFS_IRQ_STAT, 32'h2, 32'h2, "clear event");
        apb(1'b1, OFS_CTRL, 32'h10);
        toggle_bits <= 1'b0;
        look(300);
        rchk(OFS_STATUS, 32'h3, 32'h0, "disabled");
        byte_chk(8'h3c, 8'h3c);
        toggle_bits <= 1'b1;
        $display("Test internal loss done");
    endtask

    task automatic t_ext();
        apb(1'b1, OFS_CTRL, 32'h0);
        loss_req <= 1'b1;
        look(4);
        rchk(OFS_STATUS, 32'h3, 32'h2, "ext loss");
        byte_chk(8'ha5, 8'h00);
        apb(1'b1, OFS_CTRL, 32'h20);
        byte_chk(8'ha5, 8'ha5);
        apb(1'b1, OFS_CTRL, 32'h40);
        byte_chk(8'h96, 8'h96);
        apb(1'b1, OFS_CTRL, 32'hb0);
        byte_chk(8'h69, 8'h69);
        chk("loop mute", 32'h1, {31'h0, remote_loop_mute});
        chk("tx loop", 32'h0, {31'h0, tx_loop_bit});
        loss_req <= 1'b0;
        look(4);
        chk("tx loop", 32'h1, {31'h0, tx_loop_bit});
        apb(1'b1, OFS_CTRL, 32'h80);
        toggle_bits <= 1'b0;
        look(300);
        chk("loop mute", 32'h1, {31'h0, remote_loop_mute});
        apb(1'b1, OFS_CTRL, 32'h90);
        look(2);
        chk("loop mute", 32'h0, {31'h0, remote_loop_mute});
        toggle_bits <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("Test external loss done");
    endtask

    task automatic t_lock();
        look(9000);
        rchk(OFS_STATUS, 32'h30, 32'h0, "no ref lock");
        pll_lock <= 1'b1;
        wait_state(2'h2, 400);
        chk("rx_clk_from_ref", 32'h0, {31'h0, rx_clk_from_ref});
        rchk(OFS_IRQ_STAT, 32'h8, 32'h8, "lock event");
        rec_bad <= 1'b1;
        wait_state(2'h1, 200);
        chk("rx_clk_from_ref", 32'h1, {31'h0, rx_clk_from_ref});
        rchk(OFS_IRQ_STAT, 32'h4, 32'h4, "unlock event");
        rec_bad <= 1'b0;
        wait_state(2'h2, 300);
        loss_req <= 1'b1;
        wait_state(2'h1, 4);
        loss_req <= 1'b0;
        wait_state(2'h2, 300);
        $display("Test lock done");
    endtask

    task automatic t_bypass();
        apb(1'b1, OFS_CTRL, 32'h08);
        bypass_mode <= 1'b1;
        wait_state(2'h3, 4);
        toggle_bits <= 1'b0;
        look(300);
        rchk(OFS_STATUS, 32'h1, 32'h1, "bypass loss");
        toggle_bits <= 1'b1;
        look(80);
        rchk(OFS_STATUS, 32'h1, 32'h0, "bypass clear");
        $display("Test bypass done");
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        look(2);
        t_reset();
        t_cfg();
        t_loss();
        t_ext();
        t_lock();
        t_bypass();
        stop_test();
    end
endmodule

`default_nettype wire
